// File: verilog/ffh_ctrl.sv
// Fault flag, halt-on-fault control, halt capture and AHB-Lite register slave
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module ffh_ctrl (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic [31:0]             hrdata,
  input  wire ffh_pkg::ffh_core_s core,
  input  wire logic               analyse_pin,
  input  wire logic               links_busy,
  output logic                    fault_out,
  output logic                    halted,
  output logic                    refresh_en,
  output logic                    link_in_en,
  output logic                    link_out_fetch_en,
  output logic                    proc_stop,
  output logic [31:0]             top_reg,
  output logic                    irq
);
  import ffh_pkg::*;

  ffh_state_s s_reg;
  ffh_state_s s_next;
  // Fault and halt-on-fault sit outside the reset so a reset keeps them
  logic       fault_reg;
  logic       fault_next;
  logic       hof_reg;
  logic       hof_next;

  logic       wr_ctl;
  logic       rd_irq;
  logic       set_ev;
  logic       fault_rise;
  logic       anlz;
  logic       busy;
  logic [31:0] ctl_w;
  // Pins leave flops; next values mirror the pin equations so timing is unchanged
  logic       fetch_reg;
  logic       fetch_next;
  logic       pstop_reg;
  logic       pstop_next;
  logic       halted_reg;
  logic       halted_next;
  // Flag level means nothing until something has set or tested it since reset
  logic       known_reg;
  logic       known_next;

  assign anlz  = s_reg.anlz_sync[1];
  assign busy  = s_reg.busy_sync[1];
  assign wr_ctl = s_reg.a_sel && s_reg.a_wr && (s_reg.a_addr == OFF_CTRL);
  assign rd_irq = s_reg.a_sel && !s_reg.a_wr && (s_reg.a_addr == OFF_IRQST);
  assign ctl_w  = wr_ctl ? hwdata : 32'h0000_0000;
  assign set_ev = core.overflow || core.div_zero || core.bounds || core.sw_set
                  || ctl_w[CTL_SETFLT];
  assign fault_rise = set_ev && !fault_reg;
  assign fetch_next  = !(s_next.anlz_sync[1] || s_next.run == FFH_HALT);
  assign pstop_next  = s_next.stop_en && fault_next;
  assign halted_next = s_next.run == FFH_HALT;
  assign known_next  = known_reg || set_ev || core.testerr || ctl_w[CTL_TESTERR];

  always_comb begin
    s_next = s_reg;
    fault_next = fault_reg;
    hof_next   = hof_reg;
    s_next.anlz_sync = {s_reg.anlz_sync[0], analyse_pin};
    s_next.busy_sync = {s_reg.busy_sync[0], links_busy};

    // Set wins over test in the same cycle
    if (core.testerr || ctl_w[CTL_TESTERR]) begin
      fault_next = 1'b0;
    end
    if (set_ev) begin
      fault_next = 1'b1;
    end
    if (core.sw_clr_hof || ctl_w[CTL_CLRHOF]) begin
      hof_next = 1'b0;
    end
    if (core.sw_set_hof || ctl_w[CTL_SETHOF]) begin
      hof_next = 1'b1;
    end

    if (core.preempt && !s_reg.hi_pri) begin
      s_next.fault_save = fault_reg;
      s_next.hof_save   = hof_reg;
      s_next.hi_pri     = 1'b1;
      hof_next          = 1'b0;
    end else if (core.hi_done && s_reg.hi_pri) begin
      fault_next    = s_reg.fault_save;
      hof_next      = s_reg.hof_save;
      s_next.hi_pri = 1'b0;
    end

    if (wr_ctl) begin
      s_next.stop_en = hwdata[CTL_STOPEN];
    end

    case (s_reg.run)
      FFH_RUN: begin
        // Only a fresh edge halts; a level already high does not
        if (fault_rise && hof_reg) begin
          s_next.run       = FFH_DRAIN;
          s_next.halt_ip   = core.ip + IP_FAULT_OFS;
          s_next.top_reg   = core.ip + IP_FAULT_OFS;
          s_next.anlz_halt = 1'b0;
          s_next.irq_st[IRQ_HALT] = 1'b1;
        end else if (anlz && core.desched) begin
          s_next.run       = FFH_DRAIN;
          s_next.halt_ip   = core.ip + IP_ANLZ_OFS;
          s_next.top_reg   = core.ip + IP_ANLZ_OFS;
          s_next.anlz_halt = 1'b1;
          s_next.irq_st[IRQ_HALT] = 1'b1;
        end
      end
      FFH_DRAIN: begin
        if (!busy) begin
          s_next.run = FFH_HALT;
          s_next.irq_st[IRQ_DRAIN] = 1'b1;
        end
      end
      FFH_HALT: begin
        s_next.run = FFH_HALT;
      end
      default: begin
        s_next.run = FFH_RUN;
      end
    endcase

    // Read clears status, but an event in the same cycle survives
    if (rd_irq) begin
      s_next.irq_st = '0;
      if (s_reg.run == FFH_RUN && s_next.run == FFH_DRAIN) begin
        s_next.irq_st[IRQ_HALT] = 1'b1;
      end
      if (s_reg.run == FFH_DRAIN && s_next.run == FFH_HALT) begin
        s_next.irq_st[IRQ_DRAIN] = 1'b1;
      end
    end
    if (fault_rise) begin
      s_next.irq_st[IRQ_FAULT] = 1'b1;
    end
    if (s_reg.a_sel && s_reg.a_wr && s_reg.a_addr == OFF_IRQMSK) begin
      s_next.irq_msk = hwdata[IRQ_W-1:0];
    end

    s_next.fault = fault_next;
    s_next.hof   = hof_next;
    s_next.irq   = |(s_next.irq_st & s_next.irq_msk);

    // AHB-Lite address phase capture; zero wait states
    s_next.a_sel  = hsel && hready && (htrans == HTRANS_NONSEQ);
    s_next.a_wr   = hwrite;
    s_next.a_addr = haddr[7:0];
    s_next.hrdata = 32'h0000_0000;
    if (hsel && hready && htrans == HTRANS_NONSEQ && !hwrite) begin
      case (haddr[7:0])
        OFF_CTRL:   s_next.hrdata[CTL_STOPEN] = s_reg.stop_en;
        OFF_STATUS: begin
          s_next.hrdata[ST_FAULT]  = fault_reg;
          s_next.hrdata[ST_HOF]    = hof_reg;
          s_next.hrdata[ST_HALTED] = s_reg.run != FFH_RUN;
          s_next.hrdata[ST_HIPRI]  = s_reg.hi_pri;
          s_next.hrdata[ST_DRAIN]  = s_reg.run == FFH_DRAIN;
          s_next.hrdata[ST_PSTOP]  = s_reg.stop_en && fault_reg;
          s_next.hrdata[ST_ANHALT] = s_reg.anlz_halt;
        end
        OFF_IRQST:  s_next.hrdata[IRQ_W-1:0] = s_reg.irq_st;
        OFF_IRQMSK: s_next.hrdata[IRQ_W-1:0] = s_reg.irq_msk;
        OFF_HALTIP: s_next.hrdata = s_reg.halt_ip;
        OFF_TOPREG: s_next.hrdata = s_reg.top_reg;
        default:    s_next.hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Flags kept across reset; power-up level undefined
  always_ff @(posedge hclk) begin
    fault_reg <= fault_next;
    hof_reg   <= hof_next;
    pstop_reg <= pstop_next;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '{run: FFH_RUN, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fetch_reg  <= 1'b1;
      halted_reg <= 1'b0;
      known_reg  <= 1'b0;
    end else begin
      fetch_reg  <= fetch_next;
      halted_reg <= halted_next;
      known_reg  <= known_next;
    end
  end

  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign hrdata            = s_reg.hrdata;
  // Output pin straight from the flag flop, nothing reset-driven in between
  assign fault_out         = fault_reg;
  assign halted            = halted_reg;
  assign refresh_en        = 1'b1;
  assign link_in_en        = 1'b1;
  assign link_out_fetch_en = fetch_reg;
  assign proc_stop         = pstop_reg;
  assign top_reg           = s_reg.top_reg;
  assign irq               = s_reg.irq;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence fault_edge_hof;
    set_ev && !fault_reg && hof_reg && s_reg.run == FFH_RUN;
  endsequence

  pin_follow_a: assert property (known_reg |=>
    fault_out == $past(fault_next))
    else $error("fault pin differs from flag");
  fault_set_a: assert property (set_ev |=> fault_reg)
    else $error("fault event did not set flag");
  fault_hold_a: assert property (fault_reg && !core.testerr && !wr_ctl && !core.hi_done
                                 |=> fault_reg)
    else $error("fault cleared without test");
  halt_start_a: assert property (fault_edge_hof |=> s_reg.run == FFH_DRAIN)
    else $error("no halt on fault edge");
  no_level_halt_a: assert property (fault_reg && s_reg.run == FFH_RUN && !anlz
                                    |=> s_reg.run == FFH_RUN)
    else $error("halt on old fault level");
  preempt_hof_a: assert property (core.preempt && !s_reg.hi_pri && !core.sw_set_hof
                                  && !wr_ctl |=> !hof_reg)
    else $error("halt-on-fault not cleared on preempt");
  restore_a: assert property (core.hi_done && s_reg.hi_pri && !set_ev
                              |=> fault_reg == $past(s_reg.fault_save))
    else $error("fault not restored");
  fault_ip_a: assert property (fault_edge_hof |=> top_reg == $past(core.ip) + IP_FAULT_OFS)
    else $error("wrong pointer at fault halt");
  drain_a: assert property (s_reg.run == FFH_DRAIN && busy |=> !halted)
    else $error("halted before links drained");
  fetch_a: assert property (anlz |-> !link_out_fetch_en && link_in_en)
    else $error("link fetch during analyse");

  sequence analyse_desched;
    anlz && core.desched && s_reg.run == FFH_RUN && !(set_ev && !fault_reg && hof_reg);
  endsequence

  sequence preempt_low;
    core.preempt && !s_reg.hi_pri;
  endsequence

  sequence return_high;
    core.hi_done && s_reg.hi_pri;
  endsequence

  // Flag clearing, edge-only halting and the fault and halt status bits
  test_clear_a: assert property (core.testerr && !set_ev &&
    !(core.hi_done && s_reg.hi_pri) |=> !fault_reg)
    else $error("fault test did not clear flag");
  edge_only_a: assert property (set_ev && fault_reg &&
    s_reg.run == FFH_RUN && !(anlz && core.desched) |=> s_reg.run == FFH_RUN)
    else $error("halt on a fault level already high");
  irq_fault_a: assert property (fault_rise |=>
    s_reg.irq_st[IRQ_FAULT])
    else $error("fault event not recorded");
  irq_halt_a: assert property (fault_edge_hof |=>
    s_reg.irq_st[IRQ_HALT])
    else $error("halt start not recorded");

  // Halt is final and keeps its pointer
  halt_final_a: assert property (halted |=>
    halted)
    else $error("halt left without reset");
  hold_ip_a: assert property (s_reg.run == FFH_HALT |=>
    $stable(s_reg.halt_ip))
    else $error("halt pointer moved while halted");
  hold_top_a: assert property (s_reg.run == FFH_HALT |=>
    $stable(top_reg))
    else $error("top register moved while halted");
  ptr_copy_a: assert property (s_reg.run != FFH_RUN |->
    top_reg == s_reg.halt_ip)
    else $error("top register differs from halt pointer");
  read_ptr_a: assert property (hsel && hready && htrans == HTRANS_NONSEQ &&
    !hwrite && haddr[7:0] == OFF_HALTIP |=> hrdata == $past(s_reg.halt_ip))
    else $error("halt pointer read wrong");

  // Analyse path waits for a descheduling point
  analyse_ip_a: assert property (analyse_desched |=>
    top_reg == $past(core.ip) + IP_ANLZ_OFS)
    else $error("wrong pointer at analyse halt");
  analyse_mark_a: assert property (analyse_desched |=>
    s_reg.run == FFH_DRAIN && s_reg.anlz_halt)
    else $error("analyse halt not started");
  desched_wait_a: assert property (anlz && !core.desched &&
    s_reg.run == FFH_RUN && !(set_ev && !fault_reg && hof_reg) |=> s_reg.run == FFH_RUN)
    else $error("analyse halt before descheduling");

  // Drain, refresh and links while stopped
  drain_done_a: assert property (s_reg.run == FFH_DRAIN && !busy |=>
    halted)
    else $error("drain did not end when links idle");
  drain_irq_a: assert property (s_reg.run == FFH_DRAIN && !busy |=>
    s_reg.irq_st[IRQ_DRAIN])
    else $error("drain end not recorded");
  drain_links_a: assert property (s_reg.run == FFH_DRAIN |->
    link_in_en && refresh_en)
    else $error("links or refresh cut while draining");
  refresh_halt_a: assert property (halted |->
    refresh_en)
    else $error("refresh stopped while halted");
  halt_links_a: assert property (halted |->
    link_in_en && !link_out_fetch_en)
    else $error("link fetch while halted");

  // Per-process stop
  stop_proc_a: assert property (known_reg && s_reg.stop_en && fault_reg |->
    proc_stop)
    else $error("process not stopped on fault");
  stop_free_a: assert property (!s_reg.stop_en |->
    !proc_stop)
    else $error("process stopped without enable");

  // Pre-emption bookkeeping
  hipri_mark_a: assert property (preempt_low |=>
    s_reg.hi_pri)
    else $error("preemption not entered");
  lopri_back_a: assert property (return_high |=>
    !s_reg.hi_pri)
    else $error("return to low priority missed");
  save_flag_a: assert property (known_reg && core.preempt && !s_reg.hi_pri |=>
    s_reg.fault_save == $past(fault_reg))
    else $error("fault not saved on preemption");
  fault_keep_a: assert property (known_reg && core.preempt && !s_reg.hi_pri &&
    !set_ev && !core.testerr && !wr_ctl |=> fault_reg == $past(fault_reg))
    else $error("fault changed by preemption");

endmodule // ffh_ctrl

// File: common/ffh_pkg.sv
// Package: constants, register map and carrier types of the fault flag and halt control block
package ffh_pkg;

  localparam int unsigned IP_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQST  = 8'h08;
  localparam logic [7:0] OFF_IRQMSK = 8'h0C;
  localparam logic [7:0] OFF_HALTIP = 8'h10;
  localparam logic [7:0] OFF_TOPREG = 8'h14;

  // CTRL write bits (pulses except STOPEN)
  localparam int unsigned CTL_SETFLT  = 0;
  localparam int unsigned CTL_TESTERR = 1;
  localparam int unsigned CTL_SETHOF  = 2;
  localparam int unsigned CTL_CLRHOF  = 3;
  localparam int unsigned CTL_STOPEN  = 4;

  // STATUS bits
  localparam int unsigned ST_FAULT  = 0;
  localparam int unsigned ST_HOF    = 1;
  localparam int unsigned ST_HALTED = 2;
  localparam int unsigned ST_HIPRI  = 3;
  localparam int unsigned ST_DRAIN  = 4;
  localparam int unsigned ST_PSTOP  = 5;
  localparam int unsigned ST_ANHALT = 6;

  // Interrupt bits
  localparam int unsigned IRQ_W      = 3;
  localparam int unsigned IRQ_FAULT  = 0;
  localparam int unsigned IRQ_HALT   = 1;
  localparam int unsigned IRQ_DRAIN  = 2;

  // Instruction pointer offsets at a halt
  localparam logic [IP_W-1:0] IP_FAULT_OFS = 32'h0000_0002;
  localparam logic [IP_W-1:0] IP_ANLZ_OFS  = 32'h0000_0001;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  typedef enum logic [2:0] {
    FFH_RUN   = 3'b001,
    FFH_DRAIN = 3'b010,
    FFH_HALT  = 3'b100
  } ffh_run_e;

  // Core events from the execution unit, all same clock
  typedef struct packed {
    logic            overflow;
    logic            div_zero;
    logic            bounds;
    logic            sw_set;
    logic            testerr;
    logic            sw_set_hof;
    logic            sw_clr_hof;
    logic            preempt;
    logic            hi_done;
    logic            desched;
    logic [IP_W-1:0] ip;
  } ffh_core_s;

  typedef struct packed {
    logic            fault;
    logic            hof;
    logic            fault_save;
    logic            hof_save;
    logic            hi_pri;
    ffh_run_e        run;
    logic            anlz_halt;
    logic            stop_en;
    logic [IP_W-1:0] halt_ip;
    logic [IP_W-1:0] top_reg;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_msk;
    logic            a_sel;
    logic            a_wr;
    logic [7:0]      a_addr;
    logic [31:0]     hrdata;
    logic            irq;
    logic [1:0]      anlz_sync;
    logic [1:0]      busy_sync;
  } ffh_state_s;

endpackage

// File: dv/ffh_master_model.sv
// Supervising processor model watching the fault pin on its event request input
`timescale 1ns/1ps
module ffh_master_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic arm,
  input  wire logic external_event_request,
  output logic      system_stop
);
  logic last_req;

  // Pin level means nothing until software armed the watch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      system_stop <= 1'b0;
      last_req    <= 1'b0;
    end else begin
      last_req <= external_event_request;
      if (arm && external_event_request && !last_req) begin
        system_stop <= 1'b1;
      end
    end
  end
endmodule // ffh_master_model

// File: dv/ffh_ctrl_tb.sv
// Self-checking testbench of the fault flag and halt control block
`timescale 1ns/1ps
module ffh_ctrl_tb;
  import ffh_pkg::*;
  localparam logic [31:0] W_SET = 32'h1 << CTL_SETFLT;
  localparam logic [31:0] W_TST = 32'h1 << CTL_TESTERR;
  localparam logic [31:0] W_SHF = 32'h1 << CTL_SETHOF;
  localparam logic [31:0] W_CHF = 32'h1 << CTL_CLRHOF;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, analyse_pin, links_busy;
  logic [31:0] haddr, hwdata, hrdata, top_reg, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  ffh_core_s   core;
  logic        fault_out, halted, refresh_en, link_in_en, link_out_fetch_en, proc_stop, irq;
  logic        arm, system_stop;
  int          num_errors = 0;
  int          checks = 0;

  ffh_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .core(core),
    .analyse_pin(analyse_pin), .links_busy(links_busy), .fault_out(fault_out),
    .halted(halted), .refresh_en(refresh_en), .link_in_en(link_in_en),
    .link_out_fetch_en(link_out_fetch_en), .proc_stop(proc_stop), .top_reg(top_reg),
    .irq(irq));
  ffh_master_model master (.hclk(hclk), .hresetn(hresetn), .arm(arm),
    .external_event_request(fault_out), .system_stop(system_stop));

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Ready is judged just before the edge, where it is settled
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
      if (n > 50) begin
        num_errors++;
        close_out();
      end
    end while (hreadyout !== 1'b1);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    wait_ready();
    @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    // Read data taken at the edge that closes the data phase
    @(posedge hclk);
    rd = hrdata;
    @(negedge hclk);
  endtask
  task automatic pulse(input logic [9:0] ev, input logic [31:0] ip);
    @(posedge hclk);
    core <= {ev, ip};
    @(posedge hclk);
    core <= {10'h000, ip};
    repeat (2) @(negedge hclk);
  endtask
  task automatic do_reset();
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
  endtask
  task automatic wait_halt();
    for (int n = 0; n < 20 && halted !== 1'b1; n++) @(negedge hclk);
    chk("halted", 1, halted);
    if (halted !== 1'b1) close_out();
  endtask

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  initial begin
    {hresetn, hsel, hwrite, analyse_pin, links_busy, arm} = '0;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    core = '0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    // Flags start unknown, so software fixes them first
    bus(1, OFF_CTRL, W_TST | W_CHF);
    arm <= 1'b1;
    bus(0, OFF_STATUS, 0);
    chk("status fault", 0, rd[ST_FAULT]);
    chk("fault pin", 0, fault_out);
    bus(0, 8'h40, 0);
    chk("unmapped", 0, rd);
    chk("okay resp", 0, hresp);
    $display("test init done");
    for (int i = 0; i < 4; i++) begin
      pulse(10'h200 >> i, 0);
      chk("fault set", 1, fault_out);
      bus(1, OFF_CTRL, W_CHF);
      chk("fault kept", 1, fault_out);
      pulse(10'h020, 0);
      chk("fault tested", 0, fault_out);
    end
    chk("master stop", 1, system_stop);
    bus(1, OFF_CTRL, W_SET | (32'h1 << CTL_STOPEN));
    chk("sw write", 1, fault_out);
    chk("proc stop", 1, proc_stop);
    chk("others run", 0, halted);
    bus(1, OFF_CTRL, W_TST | (32'h1 << CTL_STOPEN));
    chk("proc free", 0, proc_stop);
    $display("test sources done");
    bus(1, OFF_IRQMSK, 32'h7);
    bus(0, OFF_IRQMSK, 0);
    chk("mask", 32'h7, rd);
    bus(0, OFF_IRQST, 0);
    bus(1, OFF_CTRL, W_SET);
    repeat (3) @(negedge hclk);
    chk("irq up", 1, irq);
    bus(0, OFF_IRQST, 0);
    chk("irq bit", 1, rd[IRQ_FAULT]);
    repeat (3) @(negedge hclk);
    chk("irq read clear", 0, irq);
    bus(1, OFF_IRQMSK, 0);
    bus(1, OFF_CTRL, W_TST);
    bus(1, OFF_CTRL, W_SET);
    repeat (3) @(negedge hclk);
    chk("irq masked", 0, irq);
    $display("test irq done");
    do_reset();
    bus(0, OFF_STATUS, 0);
    chk("fault after reset", 1, rd[ST_FAULT]);
    chk("pin after reset", 1, fault_out);
    bus(1, OFF_CTRL, W_SHF);
    repeat (4) @(negedge hclk);
    chk("no late halt", 0, halted);
    pulse(10'h004, 0);
    bus(0, OFF_STATUS, 0);
    chk("hi fault", 1, rd[ST_FAULT]);
    chk("hi hof", 0, rd[ST_HOF]);
    chk("hi pri", 1, rd[ST_HIPRI]);
    pulse(10'h020, 0);
    pulse(10'h010, 0);
    pulse(10'h002, 0);
    bus(0, OFF_STATUS, 0);
    chk("restored fault", 1, rd[ST_FAULT]);
    chk("restored hof", 1, rd[ST_HOF]);
    chk("restore no halt", 0, halted);
    $display("test preempt done");
    pulse(10'h020, 0);
    @(posedge hclk);
    links_busy <= 1'b1;
    pulse(10'h200, 32'h0000_1000);
    repeat (2) @(negedge hclk);
    chk("fault ptr", 32'h0000_1002, top_reg);
    bus(0, OFF_STATUS, 0);
    chk("draining", 1, rd[ST_DRAIN]);
    chk("links first", 0, halted);
    @(posedge hclk);
    links_busy <= 1'b0;
    wait_halt();
    chk("refresh", 1, refresh_en);
    bus(0, OFF_HALTIP, 0);
    chk("halt ptr", 32'h0000_1002, rd);
    bus(0, OFF_IRQST, 0);
    chk("halt events", 32'h6, rd & 32'h6);
    $display("test fault halt done");
    do_reset();
    bus(1, OFF_CTRL, W_TST | W_CHF);
    @(posedge hclk);
    analyse_pin <= 1'b1;
    repeat (4) @(negedge hclk);
    chk("out fetch", 0, link_out_fetch_en);
    chk("in enable", 1, link_in_en);
    chk("waits desched", 0, halted);
    pulse(10'h001, 32'h0000_2000);
    repeat (2) @(negedge hclk);
    chk("analyse ptr", 32'h0000_2001, top_reg);
    wait_halt();
    bus(0, OFF_STATUS, 0);
    chk("analyse halt", 1, rd[ST_ANHALT]);
    $display("test analyse done");
    close_out();
  end
endmodule // ffh_ctrl_tb
